// *** rtl/fcfd_regs.svh ***
// Constants for the floppy command flag decoder.
`ifndef FCFD_REGS_SVH
`define FCFD_REGS_SVH
// ============================================================
// Register offsets on the plain command port
// ============================================================
`define FCFD_OFS_COMMAND    4'h0
`define FCFD_OFS_STATUS     4'h1
`define FCFD_OFS_FLAGS      4'h2
`define FCFD_OFS_STEPCNT    4'h3
// ============================================================
// Command field positions
// ============================================================
`define FCFD_BIT_RATE_LO    0
`define FCFD_BIT_VERIFY     2
`define FCFD_BIT_HEAD       3
`define FCFD_BIT_TRKUPD     4
`define FCFD_BIT_MARK       0
`define FCFD_BIT_SIDE       1
`define FCFD_BIT_SETTLE     2
`define FCFD_BIT_S3         3
`define FCFD_BIT_MULTI      4
// ============================================================
// Data marks and reset values
// ============================================================
`define FCFD_MARK_NORMAL    8'hFB
`define FCFD_MARK_DELETED   8'hF8
`define FCFD_CMD_RESET      8'h00
// ============================================================
// Timing: figures in microseconds, counts at 40 MHz
// ============================================================
`define FCFD_CLK_MHZ        40
`define FCFD_STEP0_US       3000
`define FCFD_STEP1_US       6000
`define FCFD_STEP2_US       10000
`define FCFD_STEP3_US       15000
`define FCFD_SETTLE_US      15000
`define FCFD_US2CYC(us)     ((us) * `FCFD_CLK_MHZ)
`define FCFD_PULSE_CYCLES   80
`endif

// *** rtl/fcfd_pkg.sv ***
// Types shared by the floppy command flag decoder.
package fcfd_pkg;
  // ============================================================
  // Command classes
  // ============================================================
  typedef enum logic [2:0] {
    FCFD_CLS_POS,
    FCFD_CLS_SECTOR,
    FCFD_CLS_TRACK,
    FCFD_CLS_FORCE
  } fcfd_cls_e;
  // Timer state.
  typedef enum logic [1:0] {
    FCFD_ST_IDLE,
    FCFD_ST_STEP,
    FCFD_ST_SETTLE
  } fcfd_state_e;
endpackage

// *** rtl/fcfd_timer.sv ***
// Down counter used for step intervals and settling delays.
module fcfd_timer #(
  parameter int WIDTH = 24
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  expired,
  output logic [WIDTH-1:0]      count
);
  // A counter narrower than two bits leaves no room for a countdown.
  if (WIDTH < 2)
  begin : g_bad_width
    $error("WIDTH must be at least two.");
  end
  // ============================================================
  // Counter
  // ============================================================
  logic [WIDTH-1:0] count_r;   // Cycles left.
  logic             exp_r;     // One-cycle pulse when reaching zero.
  wire  [WIDTH-1:0] dec_nxt = count_r - {{(WIDTH-1){1'b0}}, 1'b1};
  // Load wins over counting so a restart is never lost.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count_r <= '0;
      exp_r   <= 1'b0;
    end
    else if (load)
    begin
      count_r <= load_value;
      exp_r   <= 1'b0;
    end
    else
    begin
      count_r <= (count_r != '0) ? dec_nxt : count_r;
      exp_r   <= (count_r == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
  assign expired = exp_r;
  assign count   = count_r;
endmodule // fcfd_timer

// *** rtl/fcfd_decoder.sv ***
// Floppy command flag decoder: command port, flag decode and write path control.
// Functional notes
// RULE1 - Low two bits choose step interval.
// RULE2 - Bit 2 enables destination track verify.
// RULE3 - Bit 3 loads or unloads head.
// RULE4 - Bit 4 makes steps update track; the plain step command (bits 6:5 = 01) leaves the track count unchanged.
// RULE5 - Write sector bit 0 picks FB/F8.
// RULE6 - Compare variant: bit 1 enables side compare.
// RULE7 - Output variant: bit 1 drives side select.
// RULE8 - Bit 2 inserts settling delay, doubled slow.
// RULE9 - Compare variant: bit 3 is expected side.
// RULE10 - Length variant: bit 3 picks size table.
// RULE11 - Bit 4 selects multiple record transfer.
// RULE12 - Force bits 0-2 arm ready/index interrupts.
// RULE13 - Force bit 3 interrupts until reset.
// RULE14 - All-zero force terminates without interrupt.
// RULE15 - Precompensation only in double density.
// RULE16 - Adjust low streams write data pulses.
// RULE17 - Adjust low keeps write gate off.
// RULE18 - Host writes commands only when idle.
// RULE19 - Step codes 3/6/10/15 ms, doubled slow.
// RULE20 - Fixed variant picks bit 1/3 meaning.
`include "fcfd_regs.svh"
module fcfd_decoder
  import fcfd_pkg::*;
#(
  parameter bit SIDE_OUTPUT_VARIANT = 1'b0, // 0: side compare, 1: side output and length.
  parameter bit SLOW_CLOCK          = 1'b0, // 1: controller runs the halved rate.
  parameter int STEP_SCALE          = 1     // Divides long counts for simulation.
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [7:0]       rdata,
  input  wire logic        drive_ready,
  input  wire logic        index_pulse,
  input  wire logic        double_density_n,
  input  wire logic        precomp_width_input,
  input  wire logic        write_request,
  input  wire logic        write_data_in,
  output logic             write_data,
  output logic             write_enable_head,
  output logic             precomp_enable,
  output logic             head_load,
  output logic             step_pulse,
  output logic             side_select_output,
  output logic [7:0]       record_marker,
  output logic [10:0]      sector_bytes,
  output logic             interrupt_request
);
  // ============================================================
  // Parameter checks
  // ============================================================
  localparam int TW = 24;   // Fits 30 ms at 40 MHz.
  localparam int MUL = SLOW_CLOCK ? 2 : 1;

  // A scale below one would divide by zero or stretch every interval.
  if (STEP_SCALE < 1)
  begin : g_bad_scale
    $error("STEP_SCALE must be at least one.");
  end
  // The longest interval at the halved rate must still fit the timer.
  if (`FCFD_US2CYC(`FCFD_STEP3_US) * 2 >= (1 << TW))
  begin : g_bad_width
    $error("Timer width too small for the longest interval.");
  end

  // Converts a time to a scaled cycle count. [RULE19]
  function automatic logic [TW-1:0] cyc(input int us);
    return TW'((`FCFD_US2CYC(us) * MUL) / STEP_SCALE);
  endfunction

  // ============================================================
  // Command register and decode
  // ============================================================
  logic [7:0]  cmd_r;            // Last command word.
  logic        busy_r;           // Command in progress.
  logic        irq_r;            // Interrupt request flag.
  logic        imm_r;            // Immediate interrupt latched.
  logic [2:0]  arm_r;            // Armed conditions.
  logic        ready_d_r;        // Ready, previous cycle.
  logic        side_r;           // Side select flip-flop.
  logic        head_r;           // Head load flip-flop.
  logic [7:0]  track_r;          // Track count updated by steps.
  logic        settle_pend_r;    // Settling delay still owed.
  fcfd_state_e state_r;          // Timer state.
  logic        wd_r;             // Registered write data.
  logic        gate_r;           // Registered write gate.
  logic [6:0]  adj_cnt_r;        // Adjustment pulse divider.
  logic        cmd_wr;           // Command port write.
  logic        load_t;           // Timer load.
  logic [TW-1:0] load_v;         // Timer load value.
  logic        t_exp;            // Timer expired.

  wire cmd_wr_w   = wr_stb && (addr == `FCFD_OFS_COMMAND);
  assign cmd_wr   = cmd_wr_w;
  // Class decode, settle_flag, arm_bits and arm_immediate_irq look at the word being written; arm_r holds the other
  // force conditions, and the remaining flag wires look at the stored command so they stay valid for the whole command.
  wire is_pos     = ~wdata[7];
  wire is_force   = (wdata[7:4] == 4'hD);
  wire is_sector  = (wdata[7:6] == 2'b10);
  wire is_track   = (wdata[7:6] == 2'b11) && !is_force;
  // The host keeps to the idle window; only force is honoured while busy. [RULE18]
  wire accept     = cmd_wr && (!busy_r || is_force);

  wire [1:0] step_rate_select = cmd_r[1:0];                 // [RULE1]
  wire verify_flag  = cmd_r[`FCFD_BIT_VERIFY];              // [RULE2]
  wire trk_update   = cmd_r[`FCFD_BIT_TRKUPD] || (cmd_r[6:5] == 2'b00); // [RULE4]
  wire deleted_mark_select = cmd_r[`FCFD_BIT_MARK];
  wire multi_record = cmd_r[`FCFD_BIT_MULTI];               // [RULE11]
  wire side_compare_en = !SIDE_OUTPUT_VARIANT && cmd_r[`FCFD_BIT_SIDE]; // [RULE6] [RULE20]
  wire expected_side   = cmd_r[`FCFD_BIT_S3];               // [RULE9]
  wire length_alt      = SIDE_OUTPUT_VARIANT && cmd_r[`FCFD_BIT_S3];   // [RULE10] [RULE20]
  wire settle_flag     = wdata[`FCFD_BIT_SETTLE];           // [RULE8]
  // Force conditions come from the word being written, because a force
  // never replaces the stored command.
  wire [3:0] arm_bits  = wdata[3:0];
  wire arm_became_ready     = arm_r[0];
  wire arm_became_not_ready = arm_r[1];
  wire arm_index_pulse      = arm_r[2];
  wire arm_immediate_irq    = arm_bits[3];

  // Step interval by rate code. [RULE1] [RULE19]
  function automatic logic [TW-1:0] step_cyc(input logic [1:0] r);
    return (r == 2'b00) ? cyc(`FCFD_STEP0_US) :
           (r == 2'b01) ? cyc(`FCFD_STEP1_US) :
           (r == 2'b10) ? cyc(`FCFD_STEP2_US) : cyc(`FCFD_STEP3_US);
  endfunction
  wire [TW-1:0] settle_cycles = cyc(`FCFD_SETTLE_US);      // [RULE8]

  // Interrupt condition events. [RULE12]
  wire ev_ready   = arm_became_ready && drive_ready && !ready_d_r;
  wire ev_unready = arm_became_not_ready && !drive_ready && ready_d_r;
  // The index event is a level; the flag is sticky, so a long pulse just holds it.
  wire ev_index   = arm_index_pulse && index_pulse;
  wire any_event  = ev_ready || ev_unready || ev_index;

  // ============================================================
  // Command acceptance and sequencing
  // ============================================================
  // A positioning command steps once, after one interval (step commands), and then settles
  // if verify is asked; sector and track commands settle when their flag asks.
  wire pos_steps  = wdata[6:5] != 2'b00;
  assign load_t = (accept && !is_force && ((is_pos && pos_steps) || (!is_pos && settle_flag)))
                || (accept && is_pos && !pos_steps && wdata[`FCFD_BIT_VERIFY])
                || (t_exp && state_r == FCFD_ST_STEP && settle_pend_r);
  // The first interval comes from the word being written, since the command
  // register only takes that word at the same edge. [RULE1]
  assign load_v = (accept && is_pos && pos_steps) ? step_cyc(wdata[1:0]) : settle_cycles;

  fcfd_timer #(.WIDTH(TW)) u_timer (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .load       (load_t),
    .load_value (load_v),
    .expired    (t_exp),
    .count      ()
  );

  // Sequencer: busy, steps, head and side state.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cmd_r         <= `FCFD_CMD_RESET;
      busy_r        <= 1'b0;
      state_r       <= FCFD_ST_IDLE;
      settle_pend_r <= 1'b0;
      head_r        <= 1'b0;
      side_r        <= 1'b0;
      track_r       <= 8'h00;
    end
    // Force ends the running command at once; the timer may run on, but with
    // the state idle its expiry neither steps nor interrupts.
    else if (accept && is_force)
    begin
      busy_r  <= 1'b0;                                      // [RULE14]
      state_r <= FCFD_ST_IDLE;
    end
    // A new command takes the flags and starts its first interval if it steps or settles.
    else if (accept)
    begin
      cmd_r         <= wdata;
      busy_r        <= load_t;
      settle_pend_r <= is_pos && pos_steps && wdata[`FCFD_BIT_VERIFY];
      state_r       <= (is_pos && pos_steps) ? FCFD_ST_STEP : (load_t ? FCFD_ST_SETTLE : FCFD_ST_IDLE);
      // The head follows h at the start; verify alone loads it at the start of a non-stepping
      // command and after the steps otherwise, so a stepping command without h keeps it off meanwhile.
      if (is_pos)
        head_r <= wdata[`FCFD_BIT_HEAD] || (wdata[`FCFD_BIT_VERIFY] && !pos_steps); // [RULE3]
      else
        head_r <= 1'b1;                                     // Sector and track commands load it.
      if (SIDE_OUTPUT_VARIANT && (is_sector || is_track))
        side_r <= wdata[`FCFD_BIT_SIDE];                    // [RULE7]
    end
    // Timer expiry ends a step or a settling interval.
    else if (t_exp)
    begin
      if (state_r == FCFD_ST_STEP)
      begin
        if (trk_update)
          track_r <= cmd_r[6] ? (cmd_r[5] ? track_r - 8'h01 : track_r + 8'h01) : track_r; // [RULE4]
        // Verify loads the head for the settling time after the last step.
        if (settle_pend_r)
          head_r <= 1'b1;                                   // [RULE2]
        settle_pend_r <= 1'b0;
        state_r <= settle_pend_r ? FCFD_ST_SETTLE : FCFD_ST_IDLE;
        busy_r  <= settle_pend_r;                           // [RULE2]
      end
      else
      begin
        state_r <= FCFD_ST_IDLE;
        busy_r  <= 1'b0;                                    // [RULE8]
      end
    end
  end

  // ============================================================
  // Interrupt conditions
  // ============================================================
  // The immediate interrupt holds until reset; condition events set the flag
  // and a new non-force command clears it, with the event winning in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq_r     <= 1'b0;
      imm_r     <= 1'b0;
      arm_r     <= 3'b000;
      ready_d_r <= 1'b0;
    end
    else
    begin
      ready_d_r <= drive_ready;
      if (accept && is_force)
      begin
        arm_r <= arm_bits[2:0];                             // [RULE12]
        imm_r <= imm_r || arm_immediate_irq;                // [RULE13]
      end
      // Events and the end of a busy command set the flag, an accepted
      // non-force command clears it; the set wins when both fall together.
      irq_r <= any_event || imm_r || (accept && is_force && arm_immediate_irq) ||
               (irq_r && !(accept && !is_force)) || (busy_r && !load_t && t_exp && !settle_pend_r);
    end
  end

  // ============================================================
  // Write path
  // ============================================================
  wire adjust_mode = !precomp_width_input;                  // [RULE16]
  // Adjustment masks precompensation so the test pulses are not shifted.
  assign precomp_enable = !double_density_n && !adjust_mode; // [RULE15]

  // Adjustment pulses come from an internal divider so no host is needed.
  // The gate is registered beside the data so both change on one edge.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      adj_cnt_r <= 7'h00;
      wd_r      <= 1'b0;
      gate_r    <= 1'b0;
    end
    else
    begin
      adj_cnt_r <= (adj_cnt_r == 7'(`FCFD_PULSE_CYCLES - 1)) ? 7'h00 : adj_cnt_r + 7'h01;
      wd_r      <= adjust_mode ? (adj_cnt_r < 7'h08) : write_data_in; // [RULE16]
      gate_r    <= write_request && !adjust_mode;                 // [RULE17]
    end
  end

  // ============================================================
  // Outputs and register reads
  // ============================================================
  assign write_data         = wd_r;
  assign write_enable_head  = gate_r;
  assign head_load          = head_r;
  assign step_pulse         = t_exp && (state_r == FCFD_ST_STEP);
  assign side_select_output = side_r;
  assign interrupt_request  = irq_r;
  assign record_marker = deleted_mark_select ? `FCFD_MARK_DELETED : `FCFD_MARK_NORMAL; // [RULE5]
  // Length table follows the variant selection. [RULE10]
  assign sector_bytes = length_alt ? (11'h080 << cmd_r[1:0]) :
                        (cmd_r[1:0] == 2'b11) ? 11'h080 : (11'h100 << cmd_r[1:0]);

  // Status word: side compare, expected side, multi-record, interrupt, busy.
  wire [7:0] status_w = {3'b000, side_compare_en, expected_side, multi_record, irq_r, busy_r};
  wire [7:0] rd_mux = (addr == `FCFD_OFS_COMMAND) ? cmd_r :
                      (addr == `FCFD_OFS_STATUS)  ? status_w :
                      (addr == `FCFD_OFS_FLAGS)   ? {4'h0, verify_flag, head_r, step_rate_select} :
                      (addr == `FCFD_OFS_STEPCNT) ? track_r : 8'h00;
  // Reads have no side effects, so software may poll the status word freely.
  // Idle cycles return zero rather than holding the last word.
  logic [7:0] rdata_r;   // Read data, valid the cycle after the strobe.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else
      rdata_r <= rd_stb ? rd_mux : 8'h00;
  end
  assign rdata = rdata_r;
endmodule // fcfd_decoder

// *** testbench/fcfd_decoder_checker.sv ***
// Concurrent checks on the ports of the floppy command flag decoder.
module fcfd_decoder_checker
  import fcfd_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       drive_ready,
  input wire logic       index_pulse,
  input wire logic       double_density_n,
  input wire logic       precomp_width_input,
  input wire logic       write_data,
  input wire logic       write_enable_head,
  input wire logic       precomp_enable,
  input wire logic       step_pulse,
  input wire logic       interrupt_request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ============================================================
  // Helper state
  // ============================================================
  logic [2:0] arm_r;  // Event conditions armed by the last command.
  logic       imm_r;  // An immediate interrupt was commanded.
  logic       imm2_r; // Same, one cycle later, to allow for latency.
  wire        cmd_wr = wr_stb && addr == 4'h0;
  wire        force_wr = cmd_wr && wdata[7:4] == 4'hD;
  // Track what the host armed; any other command disarms it.
  always_ff @(posedge sys_clk)
  begin
    arm_r <= rst ? 3'h0 : (force_wr ? wdata[2:0] : (cmd_wr ? 3'h0 : arm_r));
    imm_r <= rst ? 1'b0 : (imm_r || (force_wr && wdata[3]));
    imm2_r <= rst ? 1'b0 : imm_r;
  end
  sequence s_imm_cmd;
    force_wr && wdata[3];
  endsequence
  sequence s_quiet_cmd;
    force_wr && wdata[3:0] == 4'h0 && !interrupt_request;
  endsequence
  // ============================================================
  // Assertions
  // ============================================================
  AST_GATE_ADJUST: assert property (!precomp_width_input && $past(!precomp_width_input) |-> !write_enable_head)
    else $error("write gate active in adjust mode");
  AST_PRECOMP_SINGLE: assert property (double_density_n |-> !precomp_enable)
    else $error("precompensation in single density");
  AST_ADJ_STREAM: assert property (!precomp_width_input |-> ##[0:90] (write_data || precomp_width_input))
    else $error("no adjust pulse on write data");
  AST_STEP_WIDTH: assert property (step_pulse |=> (!step_pulse)[*8])
    else $error("step pulses too close");
  AST_IRQ_IMM: assert property (s_imm_cmd |-> ##[1:2] interrupt_request)
    else $error("immediate interrupt missing");
  AST_IRQ_HOLD: assert property (imm2_r |-> interrupt_request)
    else $error("immediate interrupt dropped before reset");
  AST_FORCE_QUIET: assert property (s_quiet_cmd |=> (!interrupt_request)[*4])
    else $error("terminate command raised interrupt");
  AST_IRQ_INDEX: assert property (arm_r[2] && $rose(index_pulse) |-> ##[1:4] interrupt_request)
    else $error("index interrupt missing");
  AST_IRQ_UP: assert property (arm_r[0] && $rose(drive_ready) |-> ##[1:4] interrupt_request)
    else $error("ready interrupt missing");
  AST_IRQ_DOWN: assert property (arm_r[1] && $fell(drive_ready) |-> ##[1:4] interrupt_request)
    else $error("not ready interrupt missing");
endmodule // fcfd_decoder_checker

bind fcfd_decoder fcfd_decoder_checker u_chk (.sys_clk, .rst, .addr, .wdata, .wr_stb, .drive_ready, .index_pulse,
  .double_density_n, .precomp_width_input, .write_data, .write_enable_head, .precomp_enable, .step_pulse,
  .interrupt_request);

// *** testbench/fcfd_drive_model.sv ***
// Behavioural disk drive: ready line, spinning index and step counter.
module fcfd_drive_model
(
  input  wire logic sys_clk,
  input  wire logic ready_cmd,
  input  wire logic step_pulse,
  output logic      drive_ready,
  output logic      index_pulse,
  output int        steps
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0; // Rotation phase in clock cycles.
  initial
  begin
    drive_ready = 1'b1;
    index_pulse = 1'b0;
    steps = 0;
  end
  // A four-cycle index pulse every 200 cycles; ready lags the request by a cycle like a real drive.
  always @(posedge sys_clk)
  begin
    ph <= (ph == 199) ? 0 : ph + 1;
    index_pulse <= (ph < 4);
    drive_ready <= ready_cmd;
    if (step_pulse)
      steps <= steps + 1;
  end
endmodule // fcfd_drive_model

// *** testbench/test_floppy_command_flag_decoder.sv ***
// Self-checking testbench for the floppy command flag decoder.
module test_floppy_command_flag_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, ready_cmd = 1;
  logic double_density_n = 1, precomp_width_input = 1, write_request = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, record_marker, d;
  logic drive_ready, index_pulse, write_data, write_enable_head, precomp_enable;
  logic head_load, step_pulse, side_select_output, interrupt_request;
  logic [10:0] sector_bytes;
  int fail_count = 0, n_checks = 0, cyc = 0, steps;
  // Long counts are divided by 1000 so a 3 ms step is 120 cycles.
  fcfd_decoder #(.SIDE_OUTPUT_VARIANT(1'b1), .STEP_SCALE(1000)) dut (.sys_clk, .rst, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .drive_ready, .index_pulse, .double_density_n, .precomp_width_input, .write_request,
    .write_data_in(1'b0), .write_data, .write_enable_head, .precomp_enable, .head_load, .step_pulse,
    .side_select_output, .record_marker, .sector_bytes, .interrupt_request);
  fcfd_drive_model drive (.sys_clk, .ready_cmd, .step_pulse, .drive_ready, .index_pulse, .steps);
  initial forever #12.5 sys_clk = ~sys_clk;
  // A hung handshake ends the run as a failure.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      test_done;
    end
  end
  // ============================================================
  // Shared tasks
  // ============================================================
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(posedge sys_clk);
    v = rdata;
  endtask
  // Poll the busy bit before a new command, bounded so a stuck one cannot hang the run.
  task automatic wait_idle;
    for (int i = 0; i < 2000; i++)
    begin
      rd(4'h1, d);
      if (d[0] === 1'b0)
        break;
    end
  endtask
  // Count cycles until the step pulse (sel 0) or interrupt (sel 1) shows.
  task automatic wait_sig(input int sel, output int n);
    n = 0;
    while ((sel == 0 ? step_pulse : interrupt_request) !== 1'b1 && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  // ============================================================
  // Scenarios
  // ============================================================
  task automatic t_reset;
    chk(record_marker, 11'h0FB);
    chk(sector_bytes, 11'h100);
    chk(head_load, 1'b0);
  endtask
  task automatic t_step;
    int n;
    int rate_us[4] = '{3000, 6000, 10000, 15000};
    wr(4'h0, 8'h5C);
    wait_sig(0, n);
    chk(head_load, 1'b1);
    chk(n >= 117 && n <= 123, 1'b1);
    wait_sig(1, n);
    chk(n >= 597 && n <= 603, 1'b1);
    rd(4'h2, d);
    chk(d, 11'h00C);
    rd(4'h3, d);
    chk(d, 11'h001);
    for (int r = 0; r < 4; r++)
    begin
      wr(4'h0, 8'h50 | 8'(r));
      wait_sig(0, n);
      chk(n >= rate_us[r] * 40 / 1000 - 3 && n <= rate_us[r] * 40 / 1000 + 3, 1'b1);
      wait_idle;
      chk(head_load, 1'b0);
      rd(4'h3, d);
      chk(d, 11'(r + 2));
    end
    wr(4'h0, 8'h40);
    wait_sig(0, n);
    wait_idle;
    rd(4'h3, d);
    chk(d, 11'h005);
    chk(11'(steps), 11'h006);
  endtask
  task automatic t_irq;
    int n;
    logic [7:0] code[3] = '{8'hD4, 8'hD1, 8'hD2};
    logic rdy0[3] = '{1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++)
    begin
      ready_cmd <= rdy0[i];
      do_reset;
      wr(4'h0, code[i]);
      repeat (4) @(posedge sys_clk);
      ready_cmd <= ~rdy0[i];
      wait_sig(1, n);
      chk(interrupt_request, 1'b1);
    end
    ready_cmd <= 1'b1;
    do_reset;
    wr(4'h0, 8'hD0);
    wait_sig(1, n);
    chk(interrupt_request, 1'b0);
    wr(4'h0, 8'hD8);
    repeat (2) @(negedge sys_clk);
    chk(interrupt_request, 1'b1);
    wr(4'h0, 8'h50);
    wait_idle;
    chk(interrupt_request, 1'b1);
    do_reset;
    @(negedge sys_clk);
    chk(interrupt_request, 1'b0);
  endtask
  task automatic t_sector;
    logic [7:0] cmd[3] = '{8'hA3, 8'hB0, 8'hE2};
    int n;
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h0, cmd[i]);
      repeat (2) @(negedge sys_clk);
      chk(side_select_output, cmd[i][1]);
      if (cmd[i][7:5] == 3'b101)
        chk(record_marker, cmd[i][0] ? 11'h0F8 : 11'h0FB);
      rd(4'h1, d);
      chk(d[2], cmd[i][4]);
      chk(d[4], 1'b0);
      wr(4'h0, 8'hD0);
      wait_idle;
    end
    // A settling delay keeps the command busy for 15 ms, 600 scaled cycles.
    wr(4'h0, 8'hA4);
    wait_sig(1, n);
    chk(n >= 597 && n <= 603, 1'b1);
  endtask
  // Any 160-cycle window of an 8-in-80 pulse train holds exactly 16 high cycles.
  task automatic t_adjust;
    int hi = 0;
    int gate = 0;
    @(posedge sys_clk);
    double_density_n <= 1'b0;
    precomp_width_input <= 1'b0;
    write_request <= 1'b1;
    repeat (3) @(posedge sys_clk);
    repeat (160)
    begin
      @(negedge sys_clk);
      hi += (write_data === 1'b1);
      gate += (write_enable_head !== 1'b0);
    end
    chk(11'(hi), 11'd16);
    chk(11'(gate), 11'h000);
    @(posedge sys_clk);
    precomp_width_input <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(write_enable_head, 1'b1);
    chk(precomp_enable, 1'b1);
    @(posedge sys_clk);
    double_density_n <= 1'b1;
    write_request <= 1'b0;
    @(negedge sys_clk);
    chk(precomp_enable, 1'b0);
  endtask
  initial
  begin
    do_reset;
    t_reset;
    t_step;
    t_irq;
    t_sector;
    t_adjust;
    test_done;
  end
endmodule // test_floppy_command_flag_decoder
